// ### logic/exec_pkg.sv
// Shared constants and types for the instruction execute block
package exec_pkg;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int PC_W            = 15;
    localparam int FILE_AW         = 7;
    localparam int DATA_W          = 8;
    localparam int LIT_W           = 11;
    localparam int BSEL_W          = 3;
    localparam int LATCH_W         = 7;
    localparam int STACK_DEPTH_DEF = 16;
    localparam int WDT_PRESC_W_DEF = 8;
    localparam int WDT_CNT_W_DEF   = 8;
    localparam logic [14:0] PC_RST    = 15'h0000;
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [6:0]  LATCH_RST = 7'h00;

    // ************************************************************
    // Program counter field positions
    // ************************************************************
    localparam int PC_JUMP_LO_HI   = 10;
    localparam int PC_JUMP_HI_LO   = 11;
    localparam int LATCH_JUMP_HI   = 6;
    localparam int LATCH_JUMP_LO   = 3;
    localparam int PC_IND_LO_HI    = 7;
    localparam int PC_IND_HI_LO    = 8;
    localparam logic [14:0] PC_STEP_ONE = 15'h0001;
    localparam logic [14:0] PC_STEP_TWO = 15'h0002;

    // ************************************************************
    // Register port map
    // ************************************************************
    localparam logic [7:0] REG_ACC_OFS    = 8'h80;
    localparam logic [7:0] REG_LATCH_OFS  = 8'h81;
    localparam logic [7:0] REG_STATUS_OFS = 8'h82;
    localparam logic [7:0] REG_PCL_OFS    = 8'h83;
    localparam logic [7:0] REG_PCH_OFS    = 8'h84;
    localparam logic [7:0] REG_WDT_OFS    = 8'h85;
    localparam int REG_SPECIAL_BIT = 7;
    localparam int ST_ZERO_BIT     = 0;
    localparam int ST_EXPIRY_BIT   = 1;
    localparam int ST_SLEEP_BIT    = 2;

    // ************************************************************
    // Operations and states
    // ************************************************************
    typedef enum logic [3:0] {
        OP_NONE          = 4'h0,
        OP_SKIP_BIT_SET  = 4'h1,
        OP_SUB_JUMP      = 4'h2,
        OP_IND_SUB_JUMP  = 4'h3,
        OP_ZERO_FILE     = 4'h4,
        OP_ZERO_ACC      = 4'h5,
        OP_WDOG_KICK     = 4'h6,
        OP_INVERT_FILE   = 4'h7,
        OP_FILE_DEC      = 4'h8
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_FLUSH = 3'b100
    } state_t;

endpackage : exec_pkg

// ### logic/file_ram.sv
// File register memory with a core port and a software port
`timescale 1ns/1ps
`default_nettype none
module file_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic [AW-1:0] rd_addr_a_i,
    input  wire logic          we_a_i,
    input  wire logic [AW-1:0] addr_a_i,
    input  wire logic [DW-1:0] wdata_a_i,
    output logic      [DW-1:0] rdata_a_o,
    input  wire logic          we_b_i,
    input  wire logic          rd_b_i,
    input  wire logic [AW-1:0] addr_b_i,
    input  wire logic [DW-1:0] wdata_b_i,
    input  wire logic          byp_en_i,
    input  wire logic [DW-1:0] byp_data_i,
    output logic      [DW-1:0] rdata_b_o
);
    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] cells;
        logic [DW-1:0]            rdata_a;
        logic [DW-1:0]            rdata_b;
    } ram_state_t;

    ram_state_t st_r;
    ram_state_t st_nxt;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.rdata_a = st_r.cells[rd_addr_a_i];
        // Software read data stand for one cycle only
        st_nxt.rdata_b = '0;
        if (rd_b_i) begin
            st_nxt.rdata_b = byp_en_i ? byp_data_i : st_r.cells[addr_b_i];
        end
        if (we_a_i) begin
            st_nxt.cells[addr_a_i] = wdata_a_i;
        end
        // Software write lands last, so it wins a same-address collision
        if (we_b_i) begin
            st_nxt.cells[addr_b_i] = wdata_b_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_a_o = st_r.rdata_a;
    assign rdata_b_o = st_r.rdata_b;
endmodule // file_ram
`default_nettype wire

// ### logic/instr_exec_core.sv
// Execute stage for bit-skip, calls, clears, watchdog kick, complement, decrement
`timescale 1ns/1ps
`default_nettype none

module instr_exec_core #(
    parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH_DEF,
    parameter int WDT_PRESC_W = exec_pkg::WDT_PRESC_W_DEF,
    parameter int WDT_CNT_W   = exec_pkg::WDT_CNT_W_DEF
) (
    input  wire logic           sys_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           instr_valid_i,
    input  wire exec_pkg::op_t  instr_op_i,
    input  wire logic [6:0]     instr_file_i,
    input  wire logic [2:0]     instr_bit_i,
    input  wire logic           instr_dest_i,
    input  wire logic [10:0]    instr_lit_i,
    input  wire logic [7:0]     reg_addr_i,
    input  wire logic [7:0]     reg_wdata_i,
    input  wire logic           reg_wr_i,
    input  wire logic           reg_rd_i,
    output logic      [7:0]     reg_rdata_o,
    output logic                busy_o,
    output logic                done_o,
    output logic                skipped_o,
    output logic      [14:0]    pc_o,
    output logic      [7:0]     acc_o,
    output logic                result_null_flag_o,
    output logic                expiry_flag_n_o,
    output logic                sleep_flag_n_o,
    output logic      [14:0]    stack_head_o
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic null_of(input logic [7:0] value);
        return (value == 8'h00);
    endfunction

    function automatic logic [14:0] pc_add(input logic [14:0] pc, input logic [14:0] step);
        return 15'(pc + step);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        exec_pkg::state_t       state;
        exec_pkg::op_t          op;
        logic [6:0]             file;
        logic [2:0]             bsel;
        logic                   dest;
        logic [10:0]            lit;
        logic [14:0]            pc;
        logic [7:0]             acc;
        logic [6:0]             latch;
        logic                   zflag;
        logic                   expiry_n;
        logic                   sleep_n;
        logic [WDT_PRESC_W-1:0] presc;
        logic [WDT_CNT_W-1:0]   wdt;
        logic                   busy;
        logic                   done;
        logic                   skipped;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;

    logic        ram_we_a;
    logic [7:0]  ram_wdata_a;
    logic [7:0]  file_val;
    logic [6:0]  ram_rd_addr;
    logic        byp_en;
    logic [7:0]  byp_data;
    logic        push;
    logic [14:0] push_data;
    logic        take;
    logic        exec_now;
    logic        presc_tick;
    logic [7:0]  result;
    logic        acc_by_core;
    logic        expiry_evt;

    assign take       = instr_valid_i && !st_r.busy;
    assign exec_now   = (st_r.state == exec_pkg::ST_EXEC);
    assign presc_tick = (st_r.presc == {WDT_PRESC_W{1'b1}});
    assign expiry_evt = presc_tick && (st_r.wdt == {WDT_CNT_W{1'b1}});

    // ************************************************************
    // Submodules
    // ************************************************************
    file_ram #(
        .DEPTH (128),
        .AW    (exec_pkg::FILE_AW),
        .DW    (exec_pkg::DATA_W)
    ) u_file_ram (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .rd_addr_a_i (ram_rd_addr),
        .we_a_i      (ram_we_a),
        .addr_a_i    (st_r.file),
        .wdata_a_i   (ram_wdata_a),
        .rdata_a_o   (file_val),
        .we_b_i      (reg_wr_i && !reg_addr_i[exec_pkg::REG_SPECIAL_BIT]),
        .rd_b_i      (reg_rd_i),
        .addr_b_i    (reg_addr_i[6:0]),
        .wdata_b_i   (reg_wdata_i),
        .byp_en_i    (byp_en),
        .byp_data_i  (byp_data),
        .rdata_b_o   (reg_rdata_o)
    );

    ret_stack #(
        .DEPTH (STACK_DEPTH),
        .W     (exec_pkg::PC_W)
    ) u_ret_stack (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .push_i      (push),
        .push_data_i (push_data),
        .head_o      (stack_head_o)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt      = st_r;
        ram_we_a    = 1'b0;
        ram_wdata_a = 8'h00;
        push        = 1'b0;
        push_data   = pc_add(st_r.pc, exec_pkg::PC_STEP_ONE);
        result      = 8'h00;
        acc_by_core = 1'b0;
        ram_rd_addr = take ? instr_file_i : st_r.file;
        st_nxt.done = 1'b0;

        // Watchdog runs on a prescaler enable, one clock only
        st_nxt.presc = WDT_PRESC_W'(st_r.presc + 1'b1);
        if (presc_tick) begin
            st_nxt.wdt = WDT_CNT_W'(st_r.wdt + 1'b1);
        end

        case (st_r.state)
            exec_pkg::ST_IDLE: begin
                if (take) begin
                    st_nxt.state = exec_pkg::ST_EXEC;
                    st_nxt.op    = instr_op_i;
                    st_nxt.file  = instr_file_i;
                    st_nxt.bsel  = instr_bit_i;
                    st_nxt.dest  = instr_dest_i;
                    st_nxt.lit   = instr_lit_i;
                end
            end
            exec_pkg::ST_EXEC: begin
                st_nxt.state   = exec_pkg::ST_IDLE;
                st_nxt.pc      = pc_add(st_r.pc, exec_pkg::PC_STEP_ONE);
                st_nxt.skipped = 1'b0;
                st_nxt.done    = 1'b1;
                case (st_r.op)
                    exec_pkg::OP_SKIP_BIT_SET: begin
                        if (file_val[st_r.bsel]) begin
                            st_nxt.pc      = pc_add(st_r.pc, exec_pkg::PC_STEP_TWO);
                            st_nxt.state   = exec_pkg::ST_FLUSH;
                            st_nxt.skipped = 1'b1;
                            st_nxt.done    = 1'b0;
                        end
                    end
                    exec_pkg::OP_SUB_JUMP: begin
                        push = 1'b1;
                        st_nxt.pc = {st_r.latch[exec_pkg::LATCH_JUMP_HI:exec_pkg::LATCH_JUMP_LO],
                                     st_r.lit[exec_pkg::PC_JUMP_LO_HI:0]};
                        st_nxt.state = exec_pkg::ST_FLUSH;
                        st_nxt.done  = 1'b0;
                    end
                    exec_pkg::OP_IND_SUB_JUMP: begin
                        push      = 1'b1;
                        st_nxt.pc = {st_r.latch, st_r.acc};
                        st_nxt.state = exec_pkg::ST_FLUSH;
                        st_nxt.done  = 1'b0;
                    end
                    exec_pkg::OP_ZERO_FILE: begin
                        ram_we_a     = 1'b1;
                        ram_wdata_a  = 8'h00;
                        st_nxt.zflag = 1'b1;
                    end
                    exec_pkg::OP_ZERO_ACC: begin
                        acc_by_core  = 1'b1;
                        st_nxt.acc   = 8'h00;
                        st_nxt.zflag = 1'b1;
                    end
                    exec_pkg::OP_WDOG_KICK: begin
                        st_nxt.presc    = '0;
                        st_nxt.wdt      = '0;
                        st_nxt.expiry_n = 1'b1;
                        st_nxt.sleep_n  = 1'b1;
                    end
                    exec_pkg::OP_INVERT_FILE,
                    exec_pkg::OP_FILE_DEC: begin
                        result = (st_r.op == exec_pkg::OP_INVERT_FILE) ? ~file_val
                                                                       : 8'(file_val - 8'h01);
                        st_nxt.zflag = null_of(result);
                        if (st_r.dest) begin
                            ram_we_a    = 1'b1;
                            ram_wdata_a = result;
                        end else begin
                            acc_by_core = 1'b1;
                            st_nxt.acc  = result;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            exec_pkg::ST_FLUSH: begin
                // The discarded slot behaves as a no-op
                st_nxt.state = exec_pkg::ST_IDLE;
                st_nxt.done  = 1'b1;
            end
            default: begin
                st_nxt.state = exec_pkg::ST_IDLE;
            end
        endcase

        // Expiry is a hardware event and wins over a kick in the same cycle
        if (expiry_evt) begin
            st_nxt.expiry_n = 1'b0;
        end

        // Software writes; the core owns the accumulator while it updates it
        if (reg_wr_i && (reg_addr_i == exec_pkg::REG_ACC_OFS) && !acc_by_core) begin
            st_nxt.acc = reg_wdata_i;
        end
        if (reg_wr_i && (reg_addr_i == exec_pkg::REG_LATCH_OFS)) begin
            st_nxt.latch = reg_wdata_i[6:0];
        end

        st_nxt.busy = (st_nxt.state != exec_pkg::ST_IDLE);
    end

    // ************************************************************
    // Software read of core registers
    // ************************************************************
    always_comb begin
        byp_en   = reg_addr_i[exec_pkg::REG_SPECIAL_BIT];
        byp_data = 8'h00;
        if (reg_addr_i == exec_pkg::REG_ACC_OFS) begin
            byp_data = st_r.acc;
        end else if (reg_addr_i == exec_pkg::REG_LATCH_OFS) begin
            byp_data = {1'b0, st_r.latch};
        end else if (reg_addr_i == exec_pkg::REG_STATUS_OFS) begin
            byp_data = {5'h00, st_r.sleep_n, st_r.expiry_n, st_r.zflag};
        end else if (reg_addr_i == exec_pkg::REG_PCL_OFS) begin
            byp_data = st_r.pc[7:0];
        end else if (reg_addr_i == exec_pkg::REG_PCH_OFS) begin
            byp_data = {1'b0, st_r.pc[14:8]};
        end else if (reg_addr_i == exec_pkg::REG_WDT_OFS) begin
            byp_data = 8'(st_r.wdt);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r          <= '0;
            st_r.state    <= exec_pkg::ST_IDLE;
            st_r.op       <= exec_pkg::OP_NONE;
            st_r.pc       <= exec_pkg::PC_RST;
            st_r.acc      <= exec_pkg::ACC_RST;
            st_r.latch    <= exec_pkg::LATCH_RST;
            st_r.expiry_n <= 1'b1;
            st_r.sleep_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o             = st_r.busy;
    assign done_o             = st_r.done;
    assign skipped_o          = st_r.skipped;
    assign pc_o               = st_r.pc;
    assign acc_o              = st_r.acc;
    assign result_null_flag_o = st_r.zflag;
    assign expiry_flag_n_o    = st_r.expiry_n;
    assign sleep_flag_n_o     = st_r.sleep_n;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_second_slot;
        (st_r.state == exec_pkg::ST_FLUSH) && !st_r.done ##1 st_r.done && !st_r.busy;
    endsequence

    sequence s_one_slot;
        st_r.done && (st_r.state == exec_pkg::ST_IDLE);
    endsequence

    skip_taken_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_SKIP_BIT_SET && file_val[st_r.bsel]
        |=> st_r.skipped && pc_o == pc_add($past(st_r.pc), exec_pkg::PC_STEP_TWO) ##0 s_second_slot)
        else $error("skip on set bit not two slots");

    skip_clear_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_SKIP_BIT_SET && !file_val[st_r.bsel]
        |=> !st_r.skipped and s_one_slot)
        else $error("clear bit wrongly skipped");

    call_push_a: assert property (
        exec_now && (st_r.op == exec_pkg::OP_SUB_JUMP || st_r.op == exec_pkg::OP_IND_SUB_JUMP)
        |=> stack_head_o == pc_add($past(st_r.pc), exec_pkg::PC_STEP_ONE))
        else $error("return address not pushed");

    call_target_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_SUB_JUMP
        |=> pc_o == {$past(st_r.latch[6:3]), $past(st_r.lit)})
        else $error("direct call target wrong");

    call_timing_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_SUB_JUMP
        |=> $stable(result_null_flag_o) and s_second_slot)
        else $error("direct call timing or flags wrong");

    indirect_subroutine_jump_target_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_IND_SUB_JUMP
        |=> pc_o == {$past(st_r.latch), $past(st_r.acc)})
        else $error("indirect call target wrong");

    indirect_subroutine_jump_timing_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_IND_SUB_JUMP
        |=> $stable(result_null_flag_o) && ($stable(expiry_flag_n_o) || $past(expiry_evt)) and s_second_slot)
        else $error("indirect call timing or flags wrong");

    clear_file_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_ZERO_FILE
        |-> ram_we_a && ram_wdata_a == 8'h00 ##1 (result_null_flag_o and s_one_slot))
        else $error("file clear wrong");

    clear_acc_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_ZERO_ACC
        |=> acc_o == 8'h00 && result_null_flag_o)
        else $error("accumulator clear wrong");

    wdog_kick_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_WDOG_KICK
        |=> st_r.wdt == '0 && st_r.presc == '0 && sleep_flag_n_o && (expiry_flag_n_o || $past(expiry_evt)))
        else $error("watchdog kick incomplete");

    invert_dest_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_INVERT_FILE && !st_r.dest
        |=> acc_o == ~$past(file_val) && !$past(ram_we_a))
        else $error("complement to accumulator wrong");

    dec_file_a: assert property (
        exec_now && st_r.op == exec_pkg::OP_FILE_DEC && st_r.dest
        |-> ram_we_a && ram_wdata_a == 8'(file_val - 8'h01) ##1 $stable(acc_o))
        else $error("decrement to file wrong");

    null_flag_a: assert property (
        exec_now && (st_r.op == exec_pkg::OP_FILE_DEC || st_r.op == exec_pkg::OP_INVERT_FILE)
        |=> result_null_flag_o == $past(null_of(result)))
        else $error("null flag does not follow result");

endmodule // instr_exec_core
`default_nettype wire

// ### logic/ret_stack.sv
// Circular return address stack with registered head
`timescale 1ns/1ps
`default_nettype none
module ret_stack #(
    parameter int DEPTH = 16,
    parameter int W     = 15
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         push_i,
    input  wire logic [W-1:0] push_data_i,
    output logic      [W-1:0] head_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] slots;
        logic [PW-1:0]           ptr;
        logic [W-1:0]            head;
    } stk_state_t;

    stk_state_t st_r;
    stk_state_t st_nxt;

    // Overflow wraps and overwrites the oldest entry, as no trap exists
    always_comb begin
        st_nxt = st_r;
        if (push_i) begin
            st_nxt.slots[st_r.ptr] = push_data_i;
            st_nxt.ptr             = PW'(st_r.ptr + 1'b1);
            st_nxt.head            = push_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign head_o = st_r.head;
endmodule // ret_stack
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic          sys_clk_i, rst_n_i, valid, dest, wr, rd, busy, done, skp, nul, exp_n, slp_n;
    exec_pkg::op_t op;
    logic [6:0]    fa;
    logic [2:0]    bs;
    logic [10:0]   lit;
    logic [7:0]    ad, wd, rdat, acc;
    logic [14:0]   pc, sh;
    int            num_errors = 0, cmp_count = 0;

    // Short watchdog so expiry shows within a few hundred cycles
    instr_exec_core #(.WDT_PRESC_W(4), .WDT_CNT_W(2)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .instr_valid_i(valid), .instr_op_i(op), .instr_file_i(fa), .instr_bit_i(bs), .instr_dest_i(dest),
        .instr_lit_i(lit), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .busy_o(busy), .done_o(done), .skipped_o(skp), .pc_o(pc), .acc_o(acc),
        .result_null_flag_o(nul), .expiry_flag_n_o(exp_n), .sleep_flag_n_o(slp_n), .stack_head_o(sh));

    task automatic end_sim();
        $display("Checks %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        ad <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        ad <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        `CHK(rdat, e)
    endtask

    task automatic ex(input exec_pkg::op_t o, input logic [6:0] f, input logic [2:0] b, input logic d,
                      input logic [10:0] k);
        @(posedge sys_clk_i);
        op <= o;
        fa <= f;
        bs <= b;
        dest <= d;
        lit <= k;
        valid <= 1'b1;
        @(posedge sys_clk_i);
        valid <= 1'b0;
        for (int i = 0; i < 8 && done !== 1'b1; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        `CHK({done, busy}, 2'b10)
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        #(25 * 4000);
        num_errors++;
        end_sim();
    end

    initial begin
        {rst_n_i, valid, dest, wr, rd, fa, bs, lit, ad, wd} = '0;
        op = exec_pkg::OP_NONE;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        reg_wr(8'h05, 8'h80);
        reg_wr(8'h81, 8'h5a);
        reg_wr(8'h80, 8'h3c);
        ex(exec_pkg::OP_SKIP_BIT_SET, 7'h05, 3'h0, 1'b0, 11'h000);
        `CHK({skp, pc}, {1'b0, 15'h0001})
        ex(exec_pkg::OP_SKIP_BIT_SET, 7'h05, 3'h7, 1'b0, 11'h000);
        `CHK({skp, pc}, {1'b1, 15'h0003})
        ex(exec_pkg::OP_ZERO_FILE, 7'h06, 3'h0, 1'b0, 11'h000);
        `CHK(nul, 1'b1)
        reg_chk(8'h06, 8'h00);
        ex(exec_pkg::OP_SUB_JUMP, 7'h00, 3'h0, 1'b0, 11'h123);
        `CHK({nul, sh, pc}, {1'b1, 15'h0005, 15'h5923})
        ex(exec_pkg::OP_IND_SUB_JUMP, 7'h00, 3'h0, 1'b0, 11'h000);
        `CHK({nul, sh, pc}, {1'b1, 15'h5924, 15'h5a3c})
        ex(exec_pkg::OP_INVERT_FILE, 7'h05, 3'h0, 1'b0, 11'h000);
        `CHK({nul, acc}, {1'b0, 8'h7f})
        reg_chk(8'h05, 8'h80);
        ex(exec_pkg::OP_FILE_DEC, 7'h05, 3'h0, 1'b1, 11'h000);
        reg_chk(8'h05, 8'h7f);
        `CHK({nul, acc}, {1'b0, 8'h7f})
        reg_wr(8'h07, 8'h01);
        ex(exec_pkg::OP_FILE_DEC, 7'h07, 3'h0, 1'b0, 11'h000);
        `CHK({nul, acc}, {1'b1, 8'h00})
        ex(exec_pkg::OP_INVERT_FILE, 7'h06, 3'h0, 1'b1, 11'h000);
        reg_chk(8'h06, 8'hff);
        reg_wr(8'h80, 8'h55);
        ex(exec_pkg::OP_ZERO_ACC, 7'h00, 3'h0, 1'b0, 11'h000);
        `CHK({nul, acc}, {1'b1, 8'h00})
        reg_chk(8'h90, 8'h00);
        // Let the watchdog expire before the kick brings the flag back
        repeat (300) @(posedge sys_clk_i);
        `CHK(exp_n, 1'b0)
        ex(exec_pkg::OP_WDOG_KICK, 7'h00, 3'h0, 1'b0, 11'h000);
        `CHK({exp_n, slp_n}, 2'b11)
        reg_chk(8'h85, 8'h00);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
